// file: hcs_cfg.svh
// Constants for the heater combustion sequencer.
`ifndef HCS_CFG_SVH
`define HCS_CFG_SVH
// Time base: clock period and the one-second sequencing tick.
`define HCS_CLK_NS      4
`define HCS_TICK_NS     1000000000
// Sequence times in seconds; HCS_OPTIME_MIN in minutes.
`define HCS_PREGLOW_S   13'h001E
`define HCS_PAUSE_S     13'h0003
`define HCS_RAMP_P_S    13'h0039
`define HCS_RAMP_D_S    13'h0038
`define HCS_HOLD_D_S    13'h000F
`define HCS_RAMP2_D_S   13'h0032
`define HCS_SUPERV_S    13'h002D
`define HCS_OPTIME_MIN  13'h004C
`define HCS_CIDLE_D_S   13'h0384
`define HCS_RD_PF_S     13'h00A8
`define HCS_RD_PP_S     13'h009D
`define HCS_RD_DF_S     13'h00AF
`define HCS_RD_DP_S     13'h0064
// Grace after a state change before a missing flame counts as flame loss.
`define HCS_FLAME_GRACE_S 13'h0003
// Temperatures in half-degree Celsius steps.
`define HCS_T_OVERHEAT  8'hD2
`define HCS_T_START     8'h78
`define HCS_T_OUTSIDE   8'h0A
`define HCS_T_PART      8'h90
`define HCS_T_IDLE      8'h99
`define HCS_T_RESUME    8'h8E
`define HCS_T_FULL_P    8'h70
`define HCS_T_FULL_D    8'h82
// Combustion air fan speed codes.
`define HCS_FAN_OFF     8'h00
`define HCS_FAN_START   8'h40
`define HCS_FAN_MID     8'hB0
`define HCS_FAN_NEAR    8'hF0
`define HCS_FAN_FULL    8'hFF
`define HCS_FAN_PART    8'h90
// Positions of the synchronised pins.
`define HCS_PIN_FLAME   0
`define HCS_PIN_OVHEAT  1
`define HCS_PIN_ENGINE  2
`define HCS_PIN_SWITCH  3
`define HCS_PIN_AUX     4
`define HCS_PIN_DIESEL  5
`define HCS_PIN_W       6
`endif

// file: hcs_pkg.sv
// Types shared by the heater combustion sequencer modules.
package hcs_pkg;

  typedef enum logic [3:0] {
    HCS_IDLE    = 4'b0000,
    HCS_STANDBY = 4'b0001,
    HCS_PREGLOW = 4'b0010,
    HCS_PAUSE   = 4'b0011,
    HCS_RAMP1   = 4'b0100,
    HCS_HOLD    = 4'b0101,
    HCS_RAMP2   = 4'b0110,
    HCS_SUPERV  = 4'b0111,
    HCS_FULL    = 4'b1000,
    HCS_PART    = 4'b1001,
    HCS_CIDLE   = 4'b1010,
    HCS_RUNDOWN = 4'b1011,
    HCS_LOCK    = 4'b1100
  } hcs_state_t;

  typedef struct packed {
    hcs_state_t  st;
    logic [12:0] sec;
    logic [12:0] optime;
    logic        restarted;
    logic        from_full;
    logic        to_lock;
    logic        cidle_long;
    logic        run_prev;
    logic [7:0]  fan;
    logic        glow;
    logic        glow_sense;
    logic        dose_on;
    logic        dose_full;
    logic        pump;
    logic        cabin;
  } hcs_ctl_t;

  // Heater operating: start sequence, heating or control idle.
  function automatic logic hcs_active(input hcs_state_t s);
    return (s >= HCS_PREGLOW) && (s <= HCS_CIDLE);
  endfunction : hcs_active

  // Fuel is being dosed.
  function automatic logic hcs_burn(input hcs_state_t s);
    return (s >= HCS_PAUSE) && (s <= HCS_PART);
  endfunction : hcs_burn

  // Flame supervision through the glow element.
  function automatic logic hcs_watch(input hcs_state_t s);
    return (s == HCS_SUPERV) || (s == HCS_FULL) || (s == HCS_PART);
  endfunction : hcs_watch

endpackage : hcs_pkg

// file: hcs_if.sv
// Carrier for synchronised pins and the one-second tick.
`timescale 1ns/10ps
`include "hcs_cfg.svh"
interface hcs_if;
  logic [`HCS_PIN_W-1:0] pins;
  logic                  tick;
  modport sync_mp (output pins);
  modport tick_mp (output tick);
  modport ctl_mp  (input pins, input tick);
endinterface : hcs_if

// file: hcs_sync.sv
// Three-stage pin synchroniser with agreement filter.
`timescale 1ns/10ps
`include "hcs_cfg.svh"
module hcs_sync #(
  parameter int W = `HCS_PIN_W
) (
  // Clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic         i_ce,
  // Raw pins
  input  wire logic [W-1:0] i_pins,
  // Filtered pins
  hcs_if.sync_mp            bus
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] o;
  } hcs_sync_t;

  hcs_sync_t q;
  hcs_sync_t d;

  // Only the second and third stages are compared; the first only feeds the second.
  always_comb begin
    d    = q;
    d.s1 = i_pins;
    d.s2 = q.s1;
    d.s3 = q.s2;
    for (int i = 0; i < W; i++) begin
      if (q.s2[i] == q.s3[i]) begin
        d.o[i] = q.s3[i];
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      q <= '0;
    end else if (i_ce) begin
      q <= d;
    end
  end

  assign bus.pins = q.o;
endmodule : hcs_sync

// file: hcs_tick.sv
// One-second tick generator for the sequence timers.
`timescale 1ns/10ps
module hcs_tick #(
  parameter int TICK_CYCLES = 250000000
) (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_ce,
  // Tick out
  hcs_if.tick_mp    bus
);
  localparam int CW = $clog2(TICK_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(TICK_CYCLES - 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          tick;
  } hcs_tick_t;

  hcs_tick_t q;
  hcs_tick_t d;

  always_comb begin
    d      = q;
    d.tick = (q.cnt == LAST);
    d.cnt  = d.tick ? '0 : q.cnt + 1'b1;
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      q <= '0;
    end else if (i_ce) begin
      q <= d;
    end
  end

  assign bus.tick = q.tick & i_ce;

  tick_gap_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_ce && q.tick) |=> !q.tick) else $error("tick lasted too long");
endmodule : hcs_tick

// file: hcs_sequencer.sv
// Heater combustion sequencer: start, flame watch, regulation, run-down.
// What this block does
// - Overheat above 105 C shuts the heater off.
// - Auxiliary variant runs the circulation pump while the heater operates.
// - Supplementary: engine start gives standby; start below 60 C and 5 C.
// - Start energises glow plug and fan; at 30 s dosing, fan pauses 3 s.
// - Petrol: fan ramps to nearly full load over 57 s.
// - Diesel: ramp 56 s, hold 15 s, ramp 50 s to nearly full.
// - At full-load fuel rate glow plug turns off and fan goes full.
// - Glow element watches the flame for 45 s and in normal operation.
// - No flame at start or flameout triggers one automatic restart.
// - Flame still absent after restart: stop fuel, lockout, fan run-down.
// - Full load changes to part load at 72 C.
// - Control idle at 76.5 C or after 76 minutes of heating.
// - From control idle resume part load at 71 C; 76.5 C idles again.
// - Petrol part load returns to full load at 56 C.
// - Diesel part load returns to full load at 65 C.
// - Diesel: idle over 900 s, then fall below 71 C gives full restart.
// - Supplementary engine-off stops combustion, fan runs down, then stops.
// - Petrol run-down is 168 s from full load, 157 s from part.
// - Diesel run-down is 175 s from full load, 100 s from part.
// - Auxiliary switch-on skips standby; glow, fan and pump start at once.
// - Auxiliary keeps pump, cabin fan and indicator on in control idle.
// - Auxiliary switch-off runs pump and fan down, then stops them.
`timescale 1ns/10ps
`include "hcs_cfg.svh"
module hcs_sequencer
  import hcs_pkg::*;
#(
  parameter int TICK_CYCLES = `HCS_TICK_NS / `HCS_CLK_NS
) (
  // Clock, reset and enable
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_ce,
  // Variant straps and user or engine requests
  input  wire logic       i_aux_variant,
  input  wire logic       i_diesel,
  input  wire logic       i_engine_on,
  input  wire logic       i_switch_on,
  // Sensing
  input  wire logic       i_flame,
  input  wire logic       i_overheat,
  input  wire logic [7:0] i_coolant,
  input  wire logic [7:0] i_outside,
  input  wire logic       i_outside_valid,
  // Actuators
  output logic            o_glow,
  output logic            o_glow_sense,
  output logic [7:0]      o_fan_speed,
  output logic            o_dose_on,
  output logic            o_dose_full,
  output logic            o_circ_pump,
  output logic            o_cabin_fan,
  output logic            o_indicator,
  // Status
  output logic            o_lockout,
  output logic [3:0]      o_state
);
  localparam logic [7:0] STEP_P  =
    8'((`HCS_FAN_NEAR - `HCS_FAN_START) / `HCS_RAMP_P_S);
  localparam logic [7:0] STEP_D  =
    8'((`HCS_FAN_MID - `HCS_FAN_START) / `HCS_RAMP_D_S);
  localparam logic [7:0] STEP_D2 =
    8'((`HCS_FAN_NEAR - `HCS_FAN_MID) / `HCS_RAMP2_D_S);
  localparam logic [12:0] OPTIME_S = 13'(`HCS_OPTIME_MIN * 60);

  hcs_if bus ();

  hcs_sync #(
    .W (`HCS_PIN_W)
  ) u_sync (
    .i_clk  (i_clk),
    .i_rst  (i_rst),
    .i_ce   (i_ce),
    .i_pins ({i_diesel, i_aux_variant, i_switch_on, i_engine_on,
              i_overheat, i_flame}),
    .bus    (bus.sync_mp)
  );

  hcs_tick #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tick (
    .i_clk (i_clk),
    .i_rst (i_rst),
    .i_ce  (i_ce),
    .bus   (bus.tick_mp)
  );

  hcs_ctl_t q;
  hcs_ctl_t d;

  logic       flame;
  logic       ovh;
  logic       aux;
  logic       dsl;
  logic       run;
  logic       tick;
  logic       start_ok;
  logic       watch;
  logic [7:0] step;
  logic [7:0] t_full;
  logic [12:0] rd_len;

  assign flame  = bus.pins[`HCS_PIN_FLAME];
  assign ovh    = bus.pins[`HCS_PIN_OVHEAT];
  assign aux    = bus.pins[`HCS_PIN_AUX];
  assign dsl    = bus.pins[`HCS_PIN_DIESEL];
  assign tick   = bus.tick;
  assign run    = aux ? bus.pins[`HCS_PIN_SWITCH]
                      : bus.pins[`HCS_PIN_ENGINE];
  assign step   = dsl ? STEP_D : STEP_P;
  // Resumed dosing needs a few cycles before the flame is seen through the
  // synchroniser, so flame loss only counts after a short grace.
  assign watch  = hcs_watch(q.st) && (q.sec >= `HCS_FLAME_GRACE_S);
  assign t_full = dsl ? `HCS_T_FULL_D : `HCS_T_FULL_P;
  // The outside sensor is optional; without it only coolant gates start.
  assign start_ok = (i_coolant < `HCS_T_START) &&
                    (!i_outside_valid ||
                     ($signed(i_outside) < $signed(`HCS_T_OUTSIDE)));
  // Run-down length follows the load at switch-off; overheat and flame-loss run-downs use the full-load length.
  always_comb begin
    if (dsl) begin
      rd_len = q.from_full ? `HCS_RD_DF_S : `HCS_RD_DP_S;
    end else begin
      rd_len = q.from_full ? `HCS_RD_PF_S : `HCS_RD_PP_S;
    end
  end

  always_comb begin
    d          = q;
    d.run_prev = run;
    if (tick && (q.sec != '1)) begin
      d.sec = q.sec + 1'b1;
    end
    if (tick && ((q.st == HCS_FULL) || (q.st == HCS_PART))) begin
      d.optime = q.optime + 1'b1;
    end
    case (q.st)
      HCS_IDLE: begin
        d.fan = `HCS_FAN_OFF;
        if (run) begin
          d.restarted = 1'b0;
          d.sec       = '0;
          d.st        = aux ? HCS_PREGLOW : HCS_STANDBY;
        end
      end
      HCS_STANDBY: begin
        if (!run) begin
          d.st = HCS_IDLE;
        end else if (start_ok) begin
          d.st  = HCS_PREGLOW;
          d.sec = '0;
        end
      end
      HCS_PREGLOW: begin
        d.fan = `HCS_FAN_START;
        if (q.sec >= `HCS_PREGLOW_S) begin
          d.st  = HCS_PAUSE;
          d.sec = '0;
          d.fan = `HCS_FAN_OFF;
        end
      end
      HCS_PAUSE: begin
        if (q.sec >= `HCS_PAUSE_S) begin
          d.st  = HCS_RAMP1;
          d.sec = '0;
          d.fan = `HCS_FAN_START;
        end
      end
      HCS_RAMP1: begin
        if (tick) begin
          d.fan = q.fan + step;
        end
        if (dsl && (q.sec >= `HCS_RAMP_D_S)) begin
          d.st  = HCS_HOLD;
          d.sec = '0;
          d.fan = `HCS_FAN_MID;
        end else if (!dsl && (q.sec >= `HCS_RAMP_P_S)) begin
          d.st  = HCS_SUPERV;
          d.sec = '0;
          d.fan = `HCS_FAN_FULL;
        end
      end
      HCS_HOLD: begin
        if (q.sec >= `HCS_HOLD_D_S) begin
          d.st  = HCS_RAMP2;
          d.sec = '0;
        end
      end
      HCS_RAMP2: begin
        if (tick) begin
          d.fan = q.fan + STEP_D2;
        end
        if (q.sec >= `HCS_RAMP2_D_S) begin
          d.st  = HCS_SUPERV;
          d.sec = '0;
          d.fan = `HCS_FAN_FULL;
        end
      end
      HCS_SUPERV: begin
        if (q.sec >= `HCS_SUPERV_S) begin
          d.st     = HCS_FULL;
          d.sec    = '0;
          d.optime = '0;
        end
      end
      HCS_FULL: begin
        d.fan = `HCS_FAN_FULL;
        if (q.optime > OPTIME_S) begin
          d.st  = HCS_CIDLE;
          d.sec = '0;
        end else if (i_coolant >= `HCS_T_PART) begin
          d.st  = HCS_PART;
          d.sec = '0;
        end
      end
      HCS_PART: begin
        d.fan = `HCS_FAN_PART;
        if ((i_coolant >= `HCS_T_IDLE) || (q.optime > OPTIME_S)) begin
          d.st  = HCS_CIDLE;
          d.sec = '0;
        end else if (i_coolant <= t_full) begin
          d.st  = HCS_FULL;
          d.sec = '0;
        end
      end
      HCS_CIDLE: begin
        d.fan    = `HCS_FAN_OFF;
        d.optime = '0;
        if (q.sec >= `HCS_CIDLE_D_S) begin
          d.cidle_long = 1'b1;
        end
        if (dsl && q.cidle_long && (i_coolant < `HCS_T_RESUME)) begin
          d.st         = HCS_PREGLOW;
          d.sec        = '0;
          d.restarted  = 1'b0;
          d.cidle_long = 1'b0;
        end else if (!(dsl && q.cidle_long) &&
                     (i_coolant <= `HCS_T_RESUME)) begin
          d.st         = HCS_PART;
          d.sec        = '0;
          d.cidle_long = 1'b0;
        end
      end
      HCS_RUNDOWN: begin
        d.fan = q.from_full ? `HCS_FAN_FULL : `HCS_FAN_PART;
        if (q.sec >= rd_len) begin
          d.st  = q.to_lock ? HCS_LOCK : HCS_IDLE;
          d.sec = '0;
          d.fan = `HCS_FAN_OFF;
        end
      end
      HCS_LOCK: begin
        d.fan = `HCS_FAN_OFF;
        if (run && !q.run_prev) begin
          d.st  = HCS_IDLE;
          d.sec = '0;
        end
      end
      default: begin
        d.st  = HCS_IDLE;
        d.sec = '0;
      end
    endcase
    // Safety overrides, overheat first, then flame loss, then switch-off.
    if (hcs_active(q.st) && ovh) begin
      d.st        = HCS_RUNDOWN;
      d.sec       = '0;
      d.to_lock   = 1'b1;
      d.from_full = 1'b1;
    end else if (watch && !flame) begin
      d.sec = '0;
      if (q.restarted) begin
        d.st        = HCS_RUNDOWN;
        d.to_lock   = 1'b1;
        d.from_full = 1'b1;
      end else begin
        d.st        = HCS_PREGLOW;
        d.restarted = 1'b1;
      end
    end else if (hcs_active(q.st) && !run) begin
      d.st        = HCS_RUNDOWN;
      d.sec       = '0;
      d.to_lock   = 1'b0;
      d.from_full = (q.st != HCS_PART) && (q.st != HCS_CIDLE);
    end
    // Entry speeds follow the next state so the fan never lags a change.
    if (d.st != q.st) begin
      case (d.st)
        HCS_PREGLOW: d.fan = `HCS_FAN_START;
        HCS_FULL:    d.fan = `HCS_FAN_FULL;
        HCS_PART:    d.fan = `HCS_FAN_PART;
        HCS_CIDLE:   d.fan = `HCS_FAN_OFF;
        HCS_RUNDOWN: d.fan = d.from_full ? `HCS_FAN_FULL : `HCS_FAN_PART;
        default: ;
      endcase
    end
    // Actuator outputs decoded from the next state so they leave flops.
    d.glow       = (d.st >= HCS_PREGLOW) && (d.st <= HCS_RAMP2);
    d.glow_sense = hcs_watch(d.st);
    d.dose_on    = hcs_burn(d.st);
    d.dose_full  = (d.st == HCS_SUPERV) || (d.st == HCS_FULL);
    d.pump       = aux && (hcs_active(d.st) ||
                   ((d.st == HCS_RUNDOWN) && !d.to_lock));
    d.cabin      = aux && hcs_active(d.st);
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      q <= '0;
    end else if (i_ce) begin
      q <= d;
    end
  end

  assign o_glow       = q.glow;
  assign o_glow_sense = q.glow_sense;
  assign o_fan_speed  = q.fan;
  assign o_dose_on    = q.dose_on;
  assign o_dose_full  = q.dose_full;
  assign o_circ_pump  = q.pump;
  assign o_cabin_fan  = q.cabin;
  assign o_indicator  = q.cabin;
  assign o_lockout    = (q.st == HCS_LOCK);
  assign o_state      = q.st;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  overheat_off_a: assert property (
    (i_ce && hcs_active(q.st) && ovh) |=> (q.st == HCS_RUNDOWN) && q.to_lock
  ) else $error("overheat did not stop the heater");
  aux_pump_a: assert property (
    (aux && hcs_active(q.st) && $stable(aux)) |-> o_circ_pump
  ) else $error("circulation pump off while heater operates");
  supp_start_a: assert property (
    (i_ce && q.st == HCS_STANDBY && run && start_ok) |=> q.st == HCS_PREGLOW
  ) else $error("standby did not start when cold");
  dose_start_a: assert property (
    $rose(q.st == HCS_PAUSE) |-> ($past(q.sec) >= `HCS_PREGLOW_S) &&
      o_dose_on && (o_fan_speed == `HCS_FAN_OFF)
  ) else $error("dosing start or fan pause wrong");
  ramp_rise_a: assert property (
    (q.st == HCS_RAMP1 && $past(q.st) == HCS_RAMP1) |->
      o_fan_speed >= $past(o_fan_speed)
  ) else $error("fan ramp fell");
  full_fuel_a: assert property (
    o_dose_full |-> !o_glow && (o_fan_speed == `HCS_FAN_FULL)
  ) else $error("glow or fan wrong at full fuel");
  flame_restart_a: assert property (
    (i_ce && watch && !flame && !ovh && !q.restarted)
      |=> q.st == HCS_PREGLOW ##1 q.restarted
  ) else $error("flame loss did not restart");
  flame_lock_a: assert property (
    (i_ce && watch && !flame && !ovh && q.restarted)
      |=> !o_dose_on && q.to_lock && (q.st == HCS_RUNDOWN)
  ) else $error("second flame loss did not lock out");
  lock_hold_a: assert property (
    (q.st == HCS_LOCK && !(run && !q.run_prev)) |=> q.st == HCS_LOCK
  ) else $error("lockout left without a fresh request");
endmodule : hcs_sequencer

// file: hcs_plant.sv
// Behavioural model of the burner flame and the overheat element.
`timescale 1ns/10ps
module hcs_plant (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  // Actuators and scenario control
  input  wire logic       i_dose_on,
  input  wire logic       i_ignite_ok,
  input  wire logic [7:0] i_coolant,
  // Sensing
  output logic            o_flame,
  output logic            o_overheat
);
  // The flame follows fuel by one cycle and dies as soon as dosing stops,
  // so a stopped pump can never be masked by a stale flame reading.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_flame <= 1'b0;
    end else begin
      o_flame <= i_dose_on & i_ignite_ok;
    end
  end
  // The element trips only strictly above 105 C (code D2).
  assign o_overheat = (i_coolant > 8'hD2);
endmodule : hcs_plant

// file: heater_combustion_sequencer_tb.sv
// Self-checking bench for the heater combustion sequencer.
`timescale 1ns/10ps
module heater_combustion_sequencer_tb
  import hcs_pkg::*;
;
  localparam int T = 4;
  logic       i_clk, i_rst, i_ce, i_aux_variant, i_diesel;
  logic       i_engine_on, i_switch_on, i_outside_valid, ignite_ok;
  logic       flame, overheat;
  logic [7:0] i_coolant, i_outside;
  logic       o_glow, o_glow_sense, o_dose_on, o_dose_full;
  logic       o_circ_pump, o_cabin_fan, o_indicator, o_lockout;
  logic [7:0] o_fan_speed;
  logic [3:0] o_state;
  int         miscompares = 0;
  int         num_checks = 0;

  hcs_sequencer #(.TICK_CYCLES(T)) u_hcs_sequencer (
    .i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce),
    .i_aux_variant(i_aux_variant), .i_diesel(i_diesel),
    .i_engine_on(i_engine_on), .i_switch_on(i_switch_on),
    .i_flame(flame), .i_overheat(overheat), .i_coolant(i_coolant),
    .i_outside(i_outside), .i_outside_valid(i_outside_valid),
    .o_glow(o_glow), .o_glow_sense(o_glow_sense),
    .o_fan_speed(o_fan_speed), .o_dose_on(o_dose_on),
    .o_dose_full(o_dose_full), .o_circ_pump(o_circ_pump),
    .o_cabin_fan(o_cabin_fan), .o_indicator(o_indicator),
    .o_lockout(o_lockout), .o_state(o_state));

  hcs_plant u_hcs_plant (
    .i_clk(i_clk), .i_rst(i_rst), .i_dose_on(o_dose_on),
    .i_ignite_ok(ignite_ok), .i_coolant(i_coolant),
    .o_flame(flame), .o_overheat(overheat));

  initial begin
    i_clk = 1'b0;
    forever #(T/2) i_clk = ~i_clk;
  end

  task automatic summarize();
    $display("Checks: %0d, mismatches: %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : summarize

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp,
                     input string msg);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h",
               $time, msg, seen, exp);
    end
  endtask : chk

  task automatic chkb(input logic seen, input logic exp, input string msg);
    chk({7'h00, seen}, {7'h00, exp}, msg);
  endtask : chkb

  task automatic chks(input hcs_state_t exp);
    chk({4'h0, o_state}, {4'h0, exp}, "state");
  endtask : chks

  // Every wait is bounded; a hang counts as a mismatch, and in wait_st ends the run.
  task automatic wait_st(input hcs_state_t s);
    int n;
    n = 0;
    while (o_state !== s && n < 6000) begin
      @(negedge i_clk);
      n++;
    end
    if (n >= 6000) begin
      miscompares++;
      $display("CHECK FAILED at %0t: timeout waiting for state", $time);
      summarize();
    end
  endtask : wait_st

  // A timed state may run up to one tick long or short of its figure.
  task automatic dur(input hcs_state_t s, input int secs);
    int n;
    n = 0;
    while (o_state === s && n < 6000) begin
      @(negedge i_clk);
      n++;
    end
    chkb(n >= (secs - 1) * T && n <= (secs + 1) * T, 1'b1, "duration");
  endtask : dur

  task automatic do_reset();
    i_rst = 1'b1;
    repeat (6) @(negedge i_clk);
    chk({o_fan_speed[7:4], o_state}, 8'h00, "reset outputs");
    chkb(o_glow | o_dose_on | o_circ_pump | o_lockout, 1'b0, "reset");
    i_rst = 1'b0;
  endtask : do_reset

  task automatic t_aux_petrol();
    i_aux_variant = 1'b1;
    i_switch_on = 1'b1;
    wait_st(HCS_PREGLOW);
    chk({o_glow, o_circ_pump, o_cabin_fan}, 8'h07, "start outputs");
    chk(o_fan_speed, 8'h40, "start fan");
    dur(HCS_PREGLOW, 30);
    chk({o_dose_on, o_fan_speed[0]}, 8'h02, "pause");
    dur(HCS_PAUSE, 3);
    dur(HCS_RAMP1, 57);
    chks(HCS_SUPERV);
    chk({o_glow, o_glow_sense, o_dose_full}, 8'h03, "glow off");
    chk(o_fan_speed, 8'hFF, "fan full");
    dur(HCS_SUPERV, 45);
    chks(HCS_FULL);
    chkb(o_glow_sense, 1'b1, "sensing in operation");
    i_coolant = 8'h8F;
    repeat (20) @(negedge i_clk);
    chks(HCS_FULL);
    i_coolant = 8'h90;
    wait_st(HCS_PART);
    chk(o_fan_speed, 8'h90, "part fan");
    i_coolant = 8'h99;
    wait_st(HCS_CIDLE);
    chk({o_dose_on, o_circ_pump, o_cabin_fan, o_indicator}, 8'h07,
        "idle outputs");
    i_ce = 1'b0;
    i_coolant = 8'h8E;
    repeat (20) @(negedge i_clk);
    chks(HCS_CIDLE);
    i_ce = 1'b1;
    wait_st(HCS_PART);
    i_coolant = 8'h99;
    wait_st(HCS_CIDLE);
    i_coolant = 8'h8E;
    wait_st(HCS_PART);
    i_coolant = 8'h70;
    wait_st(HCS_FULL);
    i_switch_on = 1'b0;
    wait_st(HCS_RUNDOWN);
    chk({o_dose_on, o_circ_pump, o_cabin_fan}, 8'h02, "run-down");
    chk(o_fan_speed, 8'hFF, "run-down fan");
    dur(HCS_RUNDOWN, 168);
    chks(HCS_IDLE);
    chk({o_circ_pump, o_fan_speed[6:0]}, 8'h00, "all off");
  endtask : t_aux_petrol

  task automatic t_lockout();
    ignite_ok = 1'b0;
    i_coolant = 8'h50;
    i_switch_on = 1'b1;
    wait_st(HCS_SUPERV);
    wait_st(HCS_PREGLOW);
    wait_st(HCS_SUPERV);
    wait_st(HCS_RUNDOWN);
    chk({o_dose_on, o_circ_pump}, 8'h00, "fuel stopped");
    chk(o_fan_speed, 8'hFF, "lockout fan");
    dur(HCS_RUNDOWN, 168);
    chkb(o_lockout, 1'b1, "lockout");
    repeat (40) @(negedge i_clk);
    chks(HCS_LOCK);
    i_switch_on = 1'b0;
    ignite_ok = 1'b1;
    repeat (10) @(negedge i_clk);
    i_switch_on = 1'b1;
    wait_st(HCS_PREGLOW);
    wait_st(HCS_FULL);
    i_coolant = 8'hD3;
    wait_st(HCS_RUNDOWN);
    chk({o_dose_on, o_glow}, 8'h00, "overheat stop");
    wait_st(HCS_LOCK);
  endtask : t_lockout

  task automatic t_supp_diesel();
    i_switch_on = 1'b0;
    i_aux_variant = 1'b0;
    i_diesel = 1'b1;
    i_coolant = 8'h78;
    i_outside_valid = 1'b1;
    i_outside = 8'h09;
    i_engine_on = 1'b1;
    wait_st(HCS_STANDBY);
    repeat (20) @(negedge i_clk);
    chks(HCS_STANDBY);
    i_coolant = 8'h77;
    i_outside = 8'h0A;
    repeat (20) @(negedge i_clk);
    chks(HCS_STANDBY);
    i_outside = 8'h09;
    wait_st(HCS_PREGLOW);
    chk({o_circ_pump, o_cabin_fan}, 8'h00, "no pump");
    dur(HCS_PREGLOW, 30);
    dur(HCS_PAUSE, 3);
    dur(HCS_RAMP1, 56);
    chk(o_fan_speed, 8'hB0, "hold fan");
    dur(HCS_HOLD, 15);
    dur(HCS_RAMP2, 50);
    wait_st(HCS_FULL);
    i_coolant = 8'h90;
    wait_st(HCS_PART);
    i_coolant = 8'h83;
    repeat (20) @(negedge i_clk);
    chks(HCS_PART);
    i_coolant = 8'h82;
    wait_st(HCS_FULL);
    i_coolant = 8'h99;
    wait_st(HCS_CIDLE);
    i_coolant = 8'h8F;
    repeat (905 * T) @(negedge i_clk);
    chks(HCS_CIDLE);
    i_coolant = 8'h8D;
    wait_st(HCS_PREGLOW);
    wait_st(HCS_FULL);
    i_coolant = 8'h90;
    wait_st(HCS_PART);
    i_engine_on = 1'b0;
    wait_st(HCS_RUNDOWN);
    chk({o_dose_on, o_circ_pump}, 8'h00, "combustion stops");
    dur(HCS_RUNDOWN, 100);
    chk(o_fan_speed, 8'h00, "fan off");
  endtask : t_supp_diesel

  initial begin
    i_rst = 1'b1;
    i_ce = 1'b1;
    i_aux_variant = 1'b0;
    i_diesel = 1'b0;
    i_engine_on = 1'b0;
    i_switch_on = 1'b0;
    i_outside_valid = 1'b0;
    i_outside = 8'h00;
    i_coolant = 8'h50;
    ignite_ok = 1'b1;
    @(negedge i_clk);
    do_reset();
    t_aux_petrol();
    t_lockout();
    do_reset();
    t_supp_diesel();
    summarize();
  end
endmodule : heater_combustion_sequencer_tb
